//--- ddr3_odt_power_down_mode_logic_bench.sv
`timescale 1ns/1ps
module ddr3_odt_power_down_mode_logic_bench;
  import ddrodt_pkg::*;
  logic        i_clk, i_reset_n, odt, cke, rtt_on, rtt_wr, async_m, window;
  ddrodt_cmd_t cmd;
  ddrodt_cfg_t cfg;
  int          bad_count, total_checks;
  always #5 i_clk = ~i_clk;
  ddrodt_host host (.i_clk(i_clk), .o_odt(odt), .o_cke(cke), .o_cmd(cmd));
  ddrodt_ctrl dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_odt(odt), .i_cke(cke),
    .i_cmd(cmd), .i_cfg(cfg), .o_rtt_on(rtt_on), .o_rtt_wr(rtt_wr),
    .o_async(async_m), .o_window(window));
  task automatic chk(input string what, input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // write latency 6, so sync termination trails odt by 4 cycles
  task automatic t_bl8();
    host.burst(6, 1'b1, 1'b0);
    chk("bl8 wr mid", rtt_wr, 1'b1);
    host.step(4);
    chk("bl8 on last", rtt_on, 1'b1);
    chk("bl8 wr last", rtt_wr, 1'b1);
    host.step(1);
    chk("bl8 on off", rtt_on, 1'b0);
    chk("bl8 wr off", rtt_wr, 1'b0);
  endtask
  task automatic t_bc4();
    host.burst(4, 1'b1, 1'b1);
    host.step(4);
    chk("bc4 wr last", rtt_wr, 1'b1);
    host.step(1);
    chk("bc4 wr off", rtt_wr, 1'b0);
    chk("bc4 on off", rtt_on, 1'b0);
  endtask
  // odt inside power-down answers after one cycle, additive latency ignored
  task automatic t_entry_exit();
    host.set_cke(1'b0);
    host.step(2);
    chk("entry window", window, 1'b1);
    chk("entry sync", async_m, 1'b0);
    host.step(2);
    chk("async on", async_m, 1'b1);
    chk("window end", window, 1'b0);
    host.burst(4, 1'b0, 1'b0);
    chk("async rtt", rtt_on, 1'b1);
    host.step(1);
    chk("async hold", rtt_on, 1'b1);
    host.step(1);
    chk("async drop", rtt_on, 1'b0);
    host.set_cke(1'b1);
    host.step(2);
    chk("exit window", window, 1'b1);
    chk("exit async", async_m, 1'b1);
    host.step(6);
    chk("exit done", async_m, 1'b0);
    chk("exit closed", window, 1'b0);
  endtask
  task automatic t_refresh();
    host.refresh();
    host.set_cke(1'b0);
    host.step(10);
    chk("rfc window", window, 1'b1);
    chk("rfc sync", async_m, 1'b0);
    host.step(4);
    chk("rfc async", async_m, 1'b1);
    host.set_cke(1'b1);
    host.step(10);
  endtask
  // with the dll kept running there is no async mode, so latency stays 4
  task automatic t_dll_on();
    cfg.dll_on_in_ppd = 1'b1;
    host.set_cke(1'b0);
    host.step(5);
    chk("dll on async", async_m, 1'b0);
    chk("dll on window", window, 1'b0);
    host.burst(4, 1'b0, 1'b0);
    chk("dll on early", rtt_on, 1'b0);
    host.step(1);
    chk("dll on late", rtt_on, 1'b1);
    host.set_cke(1'b1);
    host.step(10);
    cfg.dll_on_in_ppd = 1'b0;
    cfg.dyn_odt_en = 1'b0;
    host.burst(6, 1'b1, 1'b0);
    chk("no dyn wr", rtt_wr, 1'b0);
    host.step(10);
    cfg.dyn_odt_en = 1'b1;
  endtask
  // write latency 7 with no additive latency, active power-down, reset inside power-down
  task automatic t_latency();
    cfg.cwl = 4'h7;
    cfg.al = 4'h0;
    host.burst(6, 1'b1, 1'b0);
    chk("wl7 wr set", rtt_wr, 1'b1);
    host.step(5);
    chk("wl7 on last", rtt_on, 1'b1);
    chk("wl7 wr last", rtt_wr, 1'b1);
    host.step(1);
    chk("wl7 on off", rtt_on, 1'b0);
    chk("wl7 wr off", rtt_wr, 1'b0);
    host.step(10);
    host.set_idle(1'b0);
    host.set_cke(1'b0);
    host.step(5);
    chk("active pd async", async_m, 1'b0);
    chk("active pd window", window, 1'b0);
    host.set_cke(1'b1);
    host.step(2);
    host.set_idle(1'b1);
    host.step(20);
    host.set_cke(1'b0);
    host.step(4);
    chk("pd async", async_m, 1'b1);
    i_reset_n = 1'b0;
    host.step(2);
    chk("reset async", async_m, 1'b0);
    chk("reset window", window, 1'b0);
    i_reset_n = 1'b1;
    host.set_cke(1'b1);
    host.step(2);
    chk("after reset async", async_m, 1'b0);
    chk("after reset window", window, 1'b0);
  endtask
  initial begin
    i_clk = 1'b0;
    i_reset_n = 1'b0;
    cfg = '{cwl: 4'h5, al: 4'h1, dll_on_in_ppd: 1'b0, dyn_odt_en: 1'b1};
    repeat (3) @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    host.step(20);
    t_bl8();
    host.step(8);
    t_bc4();
    host.step(20);
    t_entry_exit();
    host.step(20);
    t_refresh();
    host.step(20);
    t_dll_on();
    host.step(20);
    t_latency();
    print_verdict();
  end
  initial begin
    #20000;
    bad_count++;
    print_verdict();
  end
endmodule // ddr3_odt_power_down_mode_logic_bench

//--- ddrodt_ctrl.sv
`timescale 1ns/1ps
module ddrodt_ctrl
  import ddrodt_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_odt,
  input  wire logic        i_cke,
  input  wire ddrodt_cmd_t i_cmd,
  input  wire ddrodt_cfg_t i_cfg,
  output logic             o_rtt_on,
  output logic             o_rtt_wr,
  output logic             o_async,
  output logic             o_window
);

  ddrodt_state_t           state_r;
  ddrodt_state_t           state_nxt;
  logic                    cke_r;
  logic                    cke_nxt;
  logic [HIST_DEPTH-1:0]   odt_hist_r;
  logic [HIST_DEPTH-1:0]   odt_hist_nxt;
  logic [HIST_DEPTH-1:0]   wr_hist_r;
  logic [HIST_DEPTH-1:0]   wr_hist_nxt;
  logic [HIST_DEPTH-1:0]   bl8_hist_r;
  logic [HIST_DEPTH-1:0]   bl8_hist_nxt;
  logic [HIST_DEPTH-1:0]   bc4_hist_r;
  logic [HIST_DEPTH-1:0]   bc4_hist_nxt;
  logic                    rtt_on_r;
  logic                    rtt_on_nxt;
  logic                    rtt_wr_r;
  logic                    rtt_wr_nxt;
  logic                    async_r;
  logic                    async_nxt;
  logic                    window_r;
  logic                    window_nxt;
  logic                    win_load;
  logic [TIMER_W-1:0]      win_value;
  logic                    win_busy;
  logic                    rfc_busy;
  logic [5:0]              wl;
  logic [5:0]              odtl;
  logic                    cke_fall;
  logic                    cke_rise;
  logic                    sync_odt;
  logic                    async_odt;
  logic                    wr_set;
  logic                    wr_clr;

  // write latency includes additive latency; on and off latencies are WL-2
  assign wl       = 6'(i_cfg.cwl) + 6'(i_cfg.al);
  assign odtl     = wl - 6'(ODTL_OFFSET);
  assign cke_fall = cke_r & ~i_cke;
  assign cke_rise = ~cke_r & i_cke;

  // history lines: bit 0 holds the value registered last edge
  assign sync_odt = hist_tap(odt_hist_r, odtl - 6'd1);
  // async path takes the pin one register old, never the same edge it is sampled
  assign async_odt = hist_tap(odt_hist_r, 6'(ASYNC_ON_MIN_CYC) - 6'd1);
  assign wr_set   = hist_tap(wr_hist_r, odtl - 6'd1);
  assign wr_clr   = hist_tap(bl8_hist_r, odtl + 6'(CWN8_EXTRA) - 6'd1)
                  | hist_tap(bc4_hist_r, odtl + 6'(CWN4_EXTRA) - 6'd1);

  // refresh timer: a refresh still running at CKE low stretches the window
  ddrodt_timer u_rfc_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_load    (i_cmd.refresh),
    .i_value   (TRFC_LOAD),
    .o_busy    (rfc_busy)
  );

  // window timer: entry delay on CKE low, DLL exit delay on CKE high
  ddrodt_timer u_win_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_load    (win_load),
    .i_value   (win_value),
    .o_busy    (win_busy)
  );

  always_comb begin
    win_load  = 1'b0;
    win_value = TCPDED_LOAD;
    state_nxt = state_r;
    unique case (state_r)
      ST_SYNC: begin
        // fast-exit setting keeps the DLL running, so no async mode at all
        if (cke_fall && i_cmd.all_idle && !i_cfg.dll_on_in_ppd) begin
          win_load  = 1'b1;
          win_value = TCPDED_LOAD;
          state_nxt = ST_ENTRY;
        end
      end
      ST_ENTRY: begin
        if (cke_rise) begin
          // short power-down: exit window reloads the timer with the DLL exit delay
          win_load  = 1'b1;
          win_value = TXPDLL_LOAD;
          state_nxt = ST_EXIT;
        end else if (!win_busy && !rfc_busy) begin
          state_nxt = ST_ASYNC;
        end
      end
      ST_ASYNC: begin
        if (cke_rise) begin
          win_load  = 1'b1;
          win_value = TXPDLL_LOAD;
          state_nxt = ST_EXIT;
        end
      end
      ST_EXIT: begin
        if (cke_fall && i_cmd.all_idle) begin
          // short idle: entry window opens before exit window closes
          win_load  = 1'b1;
          win_value = TCPDED_LOAD;
          state_nxt = ST_ENTRY;
        end else if (!win_busy) begin
          state_nxt = ST_SYNC;
        end
      end
    endcase
  end

  always_comb begin
    cke_nxt      = i_cke;
    // the ODT receiver keeps sampling through power-down
    odt_hist_nxt = {odt_hist_r[HIST_DEPTH-2:0], i_odt};
    wr_hist_nxt  = {wr_hist_r[HIST_DEPTH-2:0], i_cmd.wr & i_cfg.dyn_odt_en};
    bl8_hist_nxt = {bl8_hist_r[HIST_DEPTH-2:0], i_cmd.wr & ~i_cmd.bc4};
    bc4_hist_nxt = {bc4_hist_r[HIST_DEPTH-2:0], i_cmd.wr & i_cmd.bc4};
    async_nxt    = (state_nxt == ST_ASYNC) || (state_nxt == ST_EXIT);
    window_nxt   = (state_nxt == ST_ENTRY) || (state_nxt == ST_EXIT);
    if (async_nxt) begin
      // one cycle is the closest the clock gets to the 2 to 8.5 ns span; AL not applied
      rtt_on_nxt = async_odt;
    end else begin
      // entry window choice: synchronous latency meets both window bounds
      rtt_on_nxt = sync_odt;
    end
    // dynamic termination is only meaningful while the DLL runs
    rtt_wr_nxt = rtt_wr_r;
    if (!i_cfg.dyn_odt_en || async_nxt) begin
      rtt_wr_nxt = 1'b0;
    end else if (wr_set) begin
      rtt_wr_nxt = 1'b1;
    end else if (wr_clr) begin
      rtt_wr_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_r    <= ST_SYNC;
      cke_r      <= 1'b0;
      odt_hist_r <= HIST_RESET;
      wr_hist_r  <= HIST_RESET;
      bl8_hist_r <= HIST_RESET;
      bc4_hist_r <= HIST_RESET;
      rtt_on_r   <= 1'b0;
      rtt_wr_r   <= 1'b0;
      async_r    <= 1'b0;
      window_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cke_r      <= cke_nxt;
      odt_hist_r <= odt_hist_nxt;
      wr_hist_r  <= wr_hist_nxt;
      bl8_hist_r <= bl8_hist_nxt;
      bc4_hist_r <= bc4_hist_nxt;
      rtt_on_r   <= rtt_on_nxt;
      rtt_wr_r   <= rtt_wr_nxt;
      async_r    <= async_nxt;
      window_r   <= window_nxt;
    end
  end

  assign o_rtt_on = rtt_on_r;
  assign o_rtt_wr = rtt_wr_r;
  assign o_async  = async_r;
  assign o_window = window_r;

endmodule // ddrodt_ctrl

//--- ddrodt_ctrl_sva.sv
`timescale 1ns/1ps
module ddrodt_ctrl_sva
  import ddrodt_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_odt,
  input wire logic        i_cke,
  input wire ddrodt_cmd_t i_cmd,
  input wire ddrodt_cfg_t i_cfg,
  input wire logic        o_rtt_on,
  input wire logic        o_rtt_wr,
  input wire logic        o_async,
  input wire logic        o_window
);
  logic [15:0] odt_h, wr_h, bc4_h;
  logic [3:0]  quiet_r, rf_age_r;
  int          lat;
  assign lat = int'(i_cfg.cwl) + int'(i_cfg.al) - 2;
  // histories cleared in reset, as the design's are
  always_ff @(posedge i_clk) begin
    odt_h <= i_reset_n ? {odt_h[14:0], i_odt} : 16'h0000;
    wr_h <= i_reset_n ? {wr_h[14:0], i_cmd.wr} : 16'h0000;
    bc4_h <= i_reset_n ? {bc4_h[14:0], i_cmd.wr & i_cmd.bc4} : 16'h0000;
    quiet_r <= (!i_reset_n) ? 4'hF : (o_async | o_window) ? 4'h0
             : (quiet_r == 4'hF) ? 4'hF : quiet_r + 4'h1;
    rf_age_r <= (!i_reset_n) ? 4'hF : i_cmd.refresh ? 4'h1
              : (rf_age_r == 4'hF) ? 4'hF : rf_age_r + 4'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sync_latency_a: assert property (
    quiet_r == 4'hF && !o_async && !o_window |-> o_rtt_on == odt_h[lat])
    else $error("termination lags odt wrongly in sync mode");
  async_follow_a: assert property (
    o_async && $past(o_async) |-> o_rtt_on == $past(i_odt, 2))
    else $error("async termination not one cycle after odt");
  entry_seq_a: assert property (
    $fell(i_cke) && i_cmd.all_idle && !i_cfg.dll_on_in_ppd && quiet_r == 4'hF
    && rf_age_r > 4'hC |=> o_window [*2] ##1 (o_async && !o_window))
    else $error("power-down entry window wrong");
  refresh_hold_a: assert property (
    o_window && !o_async && rf_age_r < 4'hA |=> !o_async)
    else $error("entry window ended before refresh time");
  exit_seq_a: assert property (
    $rose(i_cke) && o_async |=> o_async && o_window ##[1:6] (!o_async && !o_window))
    else $error("power-down exit window wrong");
  async_cause_a: assert property (
    $rose(o_async) |-> !i_cfg.dll_on_in_ppd && !$past(i_cke, 3))
    else $error("async mode without frozen power-down");
  wr_set_a: assert property (
    wr_h[lat] && i_cfg.dyn_odt_en && !o_async |-> o_rtt_wr)
    else $error("write termination not selected");
  wr_clear_a: assert property (
    $fell(o_rtt_wr) |-> (wr_h[lat+6] && !bc4_h[lat+6]) || (wr_h[lat+4] && bc4_h[lat+4])
    || o_async || !i_cfg.dyn_odt_en)
    else $error("write termination dropped at wrong cycle");
  wr_forced_a: assert property (
    o_async || !i_cfg.dyn_odt_en |-> !o_rtt_wr)
    else $error("write termination while disabled");
  entry_c: cover property ($rose(o_async));
  exit_c: cover property ($fell(o_async));
  bc4_c: cover property ($fell(o_rtt_wr) && bc4_h[lat+4]);
endmodule // ddrodt_ctrl_sva
bind ddrodt_ctrl ddrodt_ctrl_sva sva (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_odt(i_odt), .i_cke(i_cke), .i_cmd(i_cmd), .i_cfg(i_cfg), .o_rtt_on(o_rtt_on),
  .o_rtt_wr(o_rtt_wr), .o_async(o_async), .o_window(o_window));

//--- ddrodt_host.sv
`timescale 1ns/1ps
module ddrodt_host
  import ddrodt_pkg::*;
(
  input  wire logic  i_clk,
  output logic       o_odt,
  output logic       o_cke,
  output ddrodt_cmd_t o_cmd
);
  initial begin
    o_odt = 1'b0;
    o_cke = 1'b1;
    o_cmd = 4'h1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // odt high for n cycles, write on the first; never shorter than the hold time
  task automatic burst(input int n, input logic wr, input logic bc4);
    int hold;
    hold = (wr && !bc4) ? 6 : 4;
    if (!o_cke) wr = 1'b0;
    o_odt = 1'b1;
    o_cmd.wr = wr;
    o_cmd.bc4 = bc4;
    step(1);
    o_cmd.wr = 1'b0;
    step(((n < hold) ? hold : n) - 1);
    o_odt = 1'b0;
  endtask
  task automatic refresh();
    o_cmd.refresh = 1'b1;
    step(1);
    o_cmd.refresh = 1'b0;
  endtask
  // caller keeps odt quiet around cke edges, where timing is uncertain
  task automatic set_cke(input logic v);
    o_cke = v;
  endtask
  // low selects active power-down, which never freezes the dll
  task automatic set_idle(input logic v);
    o_cmd.all_idle = v;
  endtask
endmodule // ddrodt_host

//--- ddrodt_pkg.sv
package ddrodt_pkg;

  // clock and timing figures, in picoseconds as printed except tCPDED in cycles, cycle counts derived
  localparam int CLK_PERIOD_PS   = 10000;
  localparam int TAONPD_MIN_PS   = 2000;
  localparam int TAONPD_MAX_PS   = 8500;
  localparam int TAOFPD_MIN_PS   = 2000;
  localparam int TAOFPD_MAX_PS   = 8500;
  localparam int TRFC_MIN_PS     = 110000;
  localparam int TXPDLL_MIN_PS   = 24000;
  localparam int TCPDED_MIN_CYC  = 1;

  // least times round up, longest times round down, never below one cycle
  localparam int ASYNC_ON_MIN_CYC  = (TAONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ASYNC_ON_MAX_RAW  = TAONPD_MAX_PS / CLK_PERIOD_PS;
  localparam int ASYNC_ON_MAX_CYC  = (ASYNC_ON_MAX_RAW < 1) ? 1 : ASYNC_ON_MAX_RAW;
  localparam int ASYNC_OFF_MIN_CYC = (TAOFPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ASYNC_OFF_MAX_RAW = TAOFPD_MAX_PS / CLK_PERIOD_PS;
  localparam int ASYNC_OFF_MAX_CYC = (ASYNC_OFF_MAX_RAW < 1) ? 1 : ASYNC_OFF_MAX_RAW;
  localparam int TRFC_CYC          = (TRFC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TXPDLL_CYC        = (TXPDLL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // latency offsets, history depth and timer width
  localparam int ODTL_OFFSET     = 2;
  localparam int CWN8_EXTRA      = 6;
  localparam int CWN4_EXTRA      = 4;
  localparam int HIST_DEPTH      = 32;
  localparam int TIMER_W         = 8;

  localparam logic [TIMER_W-1:0] TRFC_LOAD   = TIMER_W'(TRFC_CYC);
  localparam logic [TIMER_W-1:0] TXPDLL_LOAD = TIMER_W'(TXPDLL_CYC);
  localparam logic [TIMER_W-1:0] TCPDED_LOAD = TIMER_W'(TCPDED_MIN_CYC);

  localparam logic [HIST_DEPTH-1:0] HIST_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [3:0] cwl;           // cas write latency in cycles
    logic [3:0] al;            // additive latency in cycles
    logic       dll_on_in_ppd; // mode register 0 bit A12
    logic       dyn_odt_en;    // dynamic termination enabled
  } ddrodt_cfg_t;

  typedef struct packed {
    logic wr;        // write command registered this cycle
    logic bc4;       // write is a BC4 burst
    logic refresh;   // refresh command registered this cycle
    logic all_idle;  // all banks precharged
  } ddrodt_cmd_t;

  typedef enum logic [3:0] {
    ST_SYNC  = 4'h1,
    ST_ENTRY = 4'h2,
    ST_ASYNC = 4'h4,
    ST_EXIT  = 4'h8
  } ddrodt_state_t;

  // one tap of a history line, out-of-range reads as zero
  function automatic logic hist_tap(input logic [HIST_DEPTH-1:0] h, input logic [5:0] idx);
    hist_tap = (idx < 6'(HIST_DEPTH)) ? h[idx[4:0]] : 1'b0;
  endfunction

endpackage

//--- ddrodt_timer.sv
`timescale 1ns/1ps
module ddrodt_timer
  import ddrodt_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_reset_n,
  input  wire logic               i_load,
  input  wire logic [TIMER_W-1:0] i_value,
  output logic                    o_busy
);

  logic [TIMER_W-1:0] cnt_r;
  logic [TIMER_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (i_load) begin
      cnt_nxt = i_value;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - TIMER_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_busy = (cnt_r != '0);

endmodule // ddrodt_timer
